// ### hdl/hbud_top.sv
// host bus unstrobed digital i/o: four 8-bit ports plus extra control lines
// assumes registers reached by plain strobe port on clk_sys; pins outside domain
// Operation
// - mode straps choose strobed or bridge protocol
// - width straps choose 16-bit or 32-bit addressing
// - select low; second select qualifier or write
// - address selects word; window reaches the rest
// - isa qualifier: low byte, high byte enable
// - bridge qualifier: low byte and transfer size
// - read line strobes or enables reads
// - clock/write line strobes writes or clocks bridge
// - 32-line data bus, bit zero lsb
// - active-high reset clears registers asynchronously
// - oscillator times clear pulses
// - four 8-pin ports, pin 7 msb
// - per-pin direction, inputs after reset
// - per-pin standard or wired-or drive
// - read returns actual pin levels
// - output latch holds until next write
// - no handshake; direct write and read
// - request and halt inputs in status
// - extra outputs drive polarity bits
// - extra outputs standard or wired-or
// - ack line select tristates or drives
// - pclk line select tristates or drives
// - window pointer rounded down to four
// - value bit n maps to pin n
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module hbud_top
  import hbud_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic            osc_clk,
  // register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [31:0]     reg_rdata,
  // host bus pins
  input  wire logic [1:0]      interface_mode_strap,
  input  wire logic [1:0]      bus_width_strap,
  input  wire logic            primary_select_n,
  input  wire logic            secondary_select,
  input  wire logic [3:0]      byte_qualifier,
  input  wire logic            read_line_n,
  input  wire logic            bus_clock_or_write_n,
  input  wire logic [31:0]     host_data_in,
  output logic      [31:0]     host_data_out,
  output logic                 host_data_oe,
  output logic                 transfer_done_ack_n,
  output logic                 transfer_done_ack_oe,
  output logic                 clear_pulse,
  // port pins a..d packed as d:c:b:a
  input  wire logic [31:0]     port_lines_in,
  output logic      [31:0]     port_lines_out,
  output logic      [31:0]     port_lines_oe,
  // extra lines
  input  wire logic            group1_request_in,
  input  wire logic            group2_request_in,
  input  wire logic            group1_halt_trigger_in,
  input  wire logic            group2_halt_trigger_in,
  output logic                 group1_acknowledge_out,
  output logic                 group1_acknowledge_oe,
  output logic                 group2_acknowledge_out,
  output logic                 group2_acknowledge_oe,
  output logic                 group1_peripheral_clock_out,
  output logic                 group1_peripheral_clock_oe,
  output logic                 group2_peripheral_clock_out,
  output logic                 group2_peripheral_clock_oe
);

  // registers
  logic [31:0]      port_data;
  logic [31:0]      port_dir;
  logic [31:0]      drive_type_mask;
  hbud_extra_t      extra_ctrl;
  logic [7:0]       win_addr;
  logic [1:0]       clr_cnt;

  // synchronised pin levels
  logic [31:0]      port_sync;
  hbud_extra_in_t   extra_sync;
  logic [14:0]      host_sync;

  hbud_pin_sync #(.WIDTH(32)) u_port_sync (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .level_in   (port_lines_in),
    .level_sync (port_sync)
  );

  // idle-high pins cross inverted so the reset state matches idle
  hbud_pin_sync #(.WIDTH(19)) u_misc_sync (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .level_in   ({group2_request_in, group1_request_in,
                  group2_halt_trigger_in, group1_halt_trigger_in,
                  ~interface_mode_strap, ~bus_width_strap,
                  ~primary_select_n, secondary_select, byte_qualifier,
                  ~read_line_n, ~bus_clock_or_write_n, osc_clk,
                  host_data_in[1:0]}),
    .level_sync ({extra_sync.request, extra_sync.halt, host_sync})
  );

  // host pin view after synchronising
  wire logic [1:0]  s_mode      = ~host_sync[14:13];
  wire logic [1:0]  s_width     = ~host_sync[12:11];
  wire logic        s_sel_n     = ~host_sync[10];
  wire logic        s_sel2      = host_sync[9];
  wire logic [3:0]  s_qual      = host_sync[8:5];
  wire logic        s_rd_n      = ~host_sync[4];
  wire logic        s_clkwr     = ~host_sync[3];
  wire logic        s_osc       = host_sync[2];

  logic             clkwr_d;
  logic             osc_d;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clkwr_d <= 1'b1;
      osc_d   <= 1'b0;
    end else begin
      clkwr_d <= s_clkwr;
      osc_d   <= s_osc;
    end
  end

  // protocol decode
  wire logic        isa_mode    = (s_mode == MODE_STROBED);
  wire logic        bridge_mode = ~s_mode[1];
  wire logic        isa_addr    = (s_width == WIDTH_16BIT);
  wire logic        bridge_addr = (s_width == WIDTH_32BIT);
  wire logic        host_sel    = ~s_sel_n &
                                  (isa_mode ? s_sel2 : 1'b1);
  wire logic        bridge_wr   = bridge_mode & ~s_sel2;
  wire logic        clk_rise    = s_clkwr & ~clkwr_d;
  wire logic        osc_rise    = s_osc & ~osc_d;
  wire logic        isa_wr_end  = isa_mode & s_clkwr & ~clkwr_d;
  wire logic        isa_rd      = isa_mode & ~s_rd_n;
  wire logic        br_rd       = bridge_mode & ~s_rd_n & clk_rise;
  wire logic        br_wr_evt   = bridge_wr & clk_rise;

  // byte lanes from qualifier
  wire logic [1:0]  low_byte    = s_qual[3:2];
  logic      [3:0]  host_lanes;
  always_comb begin
    host_lanes = 4'hF;
    if (isa_addr) begin
      host_lanes = s_qual[1] ? (4'h1 << low_byte) : (4'h3 << low_byte);
    end else if (bridge_addr) begin
      case (s_qual[1:0])
        SIZE_ONE_BYTE: host_lanes = 4'h1 << low_byte;
        SIZE_TWO_BYTE: host_lanes = 4'h3 << low_byte;
        default:       host_lanes = 4'hF;
      endcase
    end
  end

  // host word address is not wired on this block's bus; lanes gate the data output enable and show in bus status
  wire logic        host_xfer   = host_sel & (isa_wr_end | br_wr_evt | br_rd);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      transfer_done_ack_n  <= 1'b1;
      transfer_done_ack_oe <= 1'b0;
      host_data_oe         <= 1'b0;
    end else begin
      transfer_done_ack_n  <= ~(bridge_mode & host_xfer);
      transfer_done_ack_oe <= bridge_mode & host_sel;
      host_data_oe         <= host_sel & (isa_rd | br_rd) & (|host_lanes);
    end
  end

  // register address decode
  wire logic        win_hit     = (reg_addr[7:2] == OFF_WIN_DATA[7:2]);
  wire logic [7:0]  eff_addr    = win_hit ? win_addr : reg_addr;
  wire logic        hit_data    = (eff_addr[7:2] == OFF_PORT_DATA[7:2]);
  wire logic        hit_dir     = (eff_addr[7:2] == OFF_PORT_DIR[7:2]);
  wire logic        hit_mask    = (eff_addr[7:2] == OFF_PORT_MASK[7:2]);
  wire logic        hit_extra   = (eff_addr[7:2] == OFF_EXTRA_CTRL[7:2]);
  wire logic        hit_stat    = (eff_addr[7:2] == OFF_GROUP_STAT[7:2]);
  wire logic        hit_win     = (reg_addr[7:2] == OFF_WIN_ADDR[7:2]);
  wire logic        hit_bus     = (eff_addr[7:2] == OFF_BUS_STAT[7:2]);

  // write path
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_data       <= RST_DATA;
      port_dir        <= RST_DIR;
      drive_type_mask <= RST_MASK;
      extra_ctrl      <= RST_EXTRA;
      win_addr        <= RST_WIN;
    end else if (reg_wr) begin
      if (hit_data)  port_data       <= reg_wdata;
      if (hit_dir)   port_dir        <= reg_wdata;
      if (hit_mask)  drive_type_mask <= reg_wdata;
      if (hit_extra) extra_ctrl      <= reg_wdata[EC_WIDTH-1:0];
      if (hit_win)   win_addr        <= {reg_wdata[7:2], 2'b00};
    end
  end

  // clear pulse timed by oscillator edges after a clear write
  wire logic        clr_write   = reg_wr & hit_stat;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clr_cnt <= '0;
    end else if (clr_write) begin
      clr_cnt <= 2'(CLR_PULSE_CYC);
    end else if (osc_rise && clr_cnt != '0) begin
      clr_cnt <= clr_cnt - 2'd1;
    end
  end
  assign clear_pulse = (clr_cnt != '0);

  // port drivers: bit n of each byte drives pin n
  assign port_lines_out = port_data & ~drive_type_mask;
  assign port_lines_oe  = port_dir &
                          (~drive_type_mask | ~port_data);

  // extra outputs
  genvar g;
  logic [1:0] ack_o;
  logic [1:0] ack_e;
  logic [1:0] pclk_o;
  logic [1:0] pclk_e;
  generate
    for (g = 0; g < 2; g++) begin : g_extra
      assign ack_o[g]  = extra_ctrl.ack_pol[g];
      assign ack_e[g]  = extra_ctrl.ack_line[g] &
                         (~extra_ctrl.ack_open[g] | ~extra_ctrl.ack_pol[g]);
      assign pclk_o[g] = extra_ctrl.pclk_pol[g];
      assign pclk_e[g] = extra_ctrl.pclk_line[g] &
                         (~extra_ctrl.pclk_open[g] | ~extra_ctrl.pclk_pol[g]);
    end
  endgenerate

  assign group1_acknowledge_out      = ack_o[0];
  assign group2_acknowledge_out      = ack_o[1];
  assign group1_acknowledge_oe       = ack_e[0];
  assign group2_acknowledge_oe       = ack_e[1];
  assign group1_peripheral_clock_out = pclk_o[0];
  assign group2_peripheral_clock_out = pclk_o[1];
  assign group1_peripheral_clock_oe  = pclk_e[0];
  assign group2_peripheral_clock_oe  = pclk_e[1];

  // read path
  wire logic [31:0] stat_word   = {28'h0000000,
                                   extra_sync.halt, extra_sync.request};
  wire logic [31:0] bus_word    = {22'h0, host_sync[1:0], s_mode, s_width, host_lanes};
  logic      [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_data)  rd_mux = port_sync;
    if (hit_dir)   rd_mux = port_dir;
    if (hit_mask)  rd_mux = drive_type_mask;
    if (hit_extra) rd_mux = {20'h00000, extra_ctrl};
    if (hit_stat)  rd_mux = stat_word;
    if (hit_win)   rd_mux = {24'h000000, win_addr};
    if (hit_bus)   rd_mux = bus_word;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata     <= '0;
      host_data_out <= '0;
    end else begin
      reg_rdata     <= reg_rd ? rd_mux : 32'h0000_0000;
      host_data_out <= port_sync;
    end
  end

endmodule

// ### hdl/hbud_pkg.sv
// package for the host bus unstrobed digital i/o block
// assumes one system clock domain; offsets are byte addresses of 32-bit words
package hbud_pkg;

  localparam int unsigned PORT_COUNT  = 4;
  localparam int unsigned PORT_WIDTH  = 8;

  // register byte offsets (word aligned)
  localparam logic [7:0] OFF_PORT_DATA   = 8'h00;
  localparam logic [7:0] OFF_PORT_DIR    = 8'h04;
  localparam logic [7:0] OFF_PORT_MASK   = 8'h08;
  localparam logic [7:0] OFF_EXTRA_CTRL  = 8'h0C;
  localparam logic [7:0] OFF_GROUP_STAT  = 8'h10;
  localparam logic [7:0] OFF_WIN_ADDR    = 8'h14;
  localparam logic [7:0] OFF_WIN_DATA    = 8'h18;
  localparam logic [7:0] OFF_BUS_STAT    = 8'h1C;

  // extra control field positions
  localparam int unsigned EC_ACK_POL    = 0;
  localparam int unsigned EC_PCLK_POL   = 2;
  localparam int unsigned EC_ACK_LINE   = 4;
  localparam int unsigned EC_PCLK_LINE  = 6;
  localparam int unsigned EC_ACK_OPEN   = 8;
  localparam int unsigned EC_PCLK_OPEN  = 10;
  localparam int unsigned EC_WIDTH      = 12;

  // group status positions
  localparam int unsigned GS_REQ        = 0;
  localparam int unsigned GS_HALT       = 2;

  // reset values
  localparam logic [31:0] RST_DIR       = 32'h0000_0000;
  localparam logic [31:0] RST_MASK      = 32'h0000_0000;
  localparam logic [31:0] RST_DATA      = 32'h0000_0000;
  localparam logic [11:0] RST_EXTRA     = 12'h000;
  localparam logic [7:0]  RST_WIN       = 8'h00;

  // strap codes
  localparam logic [1:0] MODE_STROBED   = 2'b11;
  localparam logic [1:0] WIDTH_16BIT    = 2'b11;
  localparam logic [1:0] WIDTH_32BIT    = 2'b01;
  localparam logic [1:0] SIZE_ONE_BYTE  = 2'b11;
  localparam logic [1:0] SIZE_TWO_BYTE  = 2'b01;

  // clear pulse timing
  localparam int unsigned OSC_MHZ       = 20;
  localparam int unsigned CLR_PULSE_NS  = 100;
  localparam int unsigned CLR_PULSE_CYC = (CLR_PULSE_NS * OSC_MHZ + 999) / 1000;

  // msb field first, so ack_pol lands on bits 1:0
  typedef struct packed {
    logic [1:0] pclk_open;
    logic [1:0] ack_open;
    logic [1:0] pclk_line;
    logic [1:0] ack_line;
    logic [1:0] pclk_pol;
    logic [1:0] ack_pol;
  } hbud_extra_t;

  typedef struct packed {
    logic [1:0] request;
    logic [1:0] halt;
  } hbud_extra_in_t;

  typedef struct packed {
    logic [1:0] ack_out;
    logic [1:0] ack_oe;
    logic [1:0] pclk_out;
    logic [1:0] pclk_oe;
  } hbud_extra_out_t;

endpackage

// ### hdl/hbud_pin_sync.sv
// two stage synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module hbud_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_sync
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1     <= '0;
      level_sync <= '0;
    end else begin
      stage1     <= level_in;
      level_sync <= stage1;
    end
  end

endmodule

// ### tb/hbud_monitor.sv
// assertions on the ports of the host bus unstrobed i/o block
// assumes it is bound to hbud_top; one clock domain, reset active high
`timescale 1ns/1ps
module hbud_monitor
  import hbud_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // pins
  input wire logic [31:0] port_lines_out,
  input wire logic [31:0] port_lines_oe,
  input wire logic        clear_pulse,
  input wire logic        group1_request_in,
  input wire logic        group1_acknowledge_out,
  input wire logic        group1_acknowledge_oe,
  input wire logic        group1_peripheral_clock_oe,
  input wire logic        group2_peripheral_clock_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic       ec_wr;
  logic       req_q;
  logic [2:0] req_age;
  logic [2:0] next_req_age;
  assign ec_wr = reg_wr && reg_addr == OFF_EXTRA_CTRL;
  // cycles the request input has held its level
  assign next_req_age = (group1_request_in != req_q) ? 3'h0 :
                        (req_age == 3'h7) ? req_age : req_age + 3'h1;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      req_q   <= 1'b0;
      req_age <= 3'h0;
    end else begin
      req_q   <= group1_request_in;
      req_age <= next_req_age;
    end
  end
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (reg_rd && reg_addr > 8'h1F |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  dir_clear_a: assert property (reg_wr && reg_addr == OFF_PORT_DIR && reg_wdata == 32'h0
    |=> port_lines_oe == 32'h0) else $error("pins still driven after all-input write");
  drive_value_a: assert property (reg_wr && reg_addr == OFF_PORT_DATA
    |=> (port_lines_out & port_lines_oe & ~$past(reg_wdata)) == 32'h0)
    else $error("pin driven high against written data");
  std_drive_a: assert property (reg_wr && reg_addr == OFF_PORT_MASK && reg_wdata == 32'h0 ##2
    reg_wr && reg_addr == OFF_PORT_DATA |=> port_lines_out == $past(reg_wdata))
    else $error("standard output differs from data");
  latch_hold_a: assert property (!reg_wr |=> $stable(port_lines_out))
    else $error("port output changed without a write");
  ack_tri_a: assert property (ec_wr && !reg_wdata[EC_ACK_LINE] |=> !group1_acknowledge_oe)
    else $error("acknowledge driven while deselected");
  pclk_tri_a: assert property (ec_wr && !reg_wdata[EC_PCLK_LINE + 1]
    |=> !group2_peripheral_clock_oe) else $error("peripheral clock driven while deselected");
  ack_drive_a: assert property (ec_wr && reg_wdata[EC_ACK_LINE] && !reg_wdata[EC_ACK_OPEN]
    |=> group1_acknowledge_oe && group1_acknowledge_out == $past(reg_wdata[EC_ACK_POL]))
    else $error("acknowledge does not follow polarity bit");
  pclk_open_a: assert property (ec_wr && reg_wdata[EC_PCLK_OPEN] && reg_wdata[EC_PCLK_POL]
    |=> !group1_peripheral_clock_oe) else $error("wired-or clock driven high");
  status_sync_a: assert property (reg_rd && reg_addr == OFF_GROUP_STAT && req_age >= 3'h3
    && group1_request_in == req_q |=> reg_rdata[GS_REQ] == $past(group1_request_in))
    else $error("request status wrong");
  clear_start_a: assert property (reg_wr && reg_addr == OFF_GROUP_STAT |-> ##[1:4] clear_pulse)
    else $error("clear pulse missing");
endmodule

// ### tb/hbud_far_end.sv
// far side of the port pins and the bridge bus clock
// assumes pins resolve to the device level where driven, else outside level
`timescale 1ns/1ps
module hbud_far_end (
  // port pins
  input  wire logic [31:0] lines_out,
  input  wire logic [31:0] lines_oe,
  input  wire logic [31:0] ext_level,
  output logic      [31:0] lines_in,
  // bus clock
  input  wire logic        frame,
  output logic             bus_clk
);
  assign lines_in = (lines_oe & lines_out) | (~lines_oe & ext_level);
  initial bus_clk = 1'b1;
  // clock stands high outside frames
  always #100 bus_clk = frame ? ~bus_clk : 1'b1;
endmodule

// ### tb/hbud_top_tb_top.sv
// self-checking bench for the host bus unstrobed i/o block
// assumes the monitor and far-end model are compiled first
`timescale 1ns/1ps
module hbud_top_tb_top;
  import hbud_pkg::*;
  logic clk_sys = 1'b0, osc_clk = 1'b0, reset = 1'b1, frame = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, psel_n = 1'b1, ssel = 1'b0, rline_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, hdin = 32'h0, ext_level = 32'h0;
  logic [31:0] reg_rdata, lin, lout, loe, rdv, mask, data, dir, hdo;
  logic [1:0]  mstrap = 2'b11, wstrap = 2'b11, req = 2'b00, halt = 2'b00;
  logic [1:0]  ack_o, ack_e, pc_o, pc_e;
  logic [3:0]  bq = 4'h0;
  logic        bclk, clr, hdoe, tack_oe;
  hbud_extra_t     xc;
  hbud_extra_out_t xe;
  int n_fail = 0, compares = 0, i;
  always #12.5 clk_sys = ~clk_sys;
  always #25 osc_clk = ~osc_clk;
  hbud_far_end u_hbud_far_end (.lines_out(lout), .lines_oe(loe), .ext_level(ext_level),
    .lines_in(lin), .frame(frame), .bus_clk(bclk));
  hbud_top u_hbud_top (.clk_sys(clk_sys), .reset(reset), .osc_clk(osc_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .interface_mode_strap(mstrap), .bus_width_strap(wstrap),
    .primary_select_n(psel_n), .secondary_select(ssel), .byte_qualifier(bq),
    .read_line_n(rline_n), .bus_clock_or_write_n(bclk), .host_data_in(hdin),
    .host_data_out(hdo), .host_data_oe(hdoe), .transfer_done_ack_n(),
    .transfer_done_ack_oe(tack_oe),
    .clear_pulse(clr), .port_lines_in(lin), .port_lines_out(lout), .port_lines_oe(loe),
    .group1_request_in(req[0]), .group2_request_in(req[1]),
    .group1_halt_trigger_in(halt[0]), .group2_halt_trigger_in(halt[1]),
    .group1_acknowledge_out(ack_o[0]), .group1_acknowledge_oe(ack_e[0]),
    .group2_acknowledge_out(ack_o[1]), .group2_acknowledge_oe(ack_e[1]),
    .group1_peripheral_clock_out(pc_o[0]), .group1_peripheral_clock_oe(pc_e[0]),
    .group2_peripheral_clock_out(pc_o[1]), .group2_peripheral_clock_oe(pc_e[1]));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic hbud_extra_out_t ex_exp(input hbud_extra_t c);
    ex_exp.ack_out  = c.ack_pol;
    ex_exp.ack_oe   = c.ack_line & (~c.ack_open | ~c.ack_pol);
    ex_exp.pclk_out = c.pclk_pol;
    ex_exp.pclk_oe  = c.pclk_line & (~c.pclk_open | ~c.pclk_pol);
  endfunction
  function automatic logic [31:0] pin_exp(input logic [31:0] dr, mk, dt, ex);
    logic [31:0] oe;
    oe = dr & ~(mk & dt);
    pin_exp = (oe & dt & ~mk) | (~oe & ex);
  endfunction
  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #250000;
    n_fail++;
    conclude;
  end
  initial begin
    void'($urandom(95));
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    chk("oe after reset", loe, 32'h0);
    chk("extra oe after reset", {28'h0, ack_e, pc_e}, 32'h0);
    $display("reset test done");
    frame <= 1'b1;
    for (i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      {mstrap, wstrap, bq, psel_n, ssel, rline_n} <= 11'($urandom());
      hdin      <= $urandom();
      ext_level <= $urandom();
      mask = (i == 0) ? 32'h0 : $urandom();
      data = (i == 1) ? 32'hFFFF_FFFF : $urandom();
      dir  = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      wr(OFF_PORT_MASK, mask);
      wr(OFF_PORT_DATA, data);
      wr(OFF_PORT_DIR, dir);
      #1 chk("port oe", loe, dir & ~(mask & data));
      chk("port out", lout, data & ~mask);
      repeat (4) @(posedge clk_sys);
      rd(OFF_PORT_DATA, rdv);
      chk("port read", rdv, pin_exp(dir, mask, data, ext_level));
      chk("host data", hdo, pin_exp(dir, mask, data, ext_level));
      chk("done ack oe", tack_oe, !mstrap[1] && !psel_n);
      if (mstrap == MODE_STROBED)
        chk("host data oe", hdoe, !psel_n && ssel && !rline_n);
    end
    frame <= 1'b0;
    $display("port test done");
    wr(OFF_PORT_MASK, 32'h0);
    wr(OFF_WIN_ADDR, 32'h0000_0006);
    wr(OFF_WIN_DATA, 32'h0000_00FF);
    #1 chk("window dir", loe, 32'h0000_00FF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, rdv);
    chk("unmapped read", rdv, 32'h0);
    chk("unmapped write", loe, 32'h0000_00FF);
    $display("window test done");
    for (i = 0; i < 20; i++) begin
      xc = (i == 0) ? 12'h030 : 12'($urandom());
      wr(OFF_EXTRA_CTRL, 32'(xc));
      xe = ex_exp(xc);
      #1 chk("extra lines", {28'h0, ack_o, ack_e, pc_o, pc_e}, 32'(xe));
    end
    $display("extra test done");
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      {req, halt} <= 4'($urandom());
      repeat (5) @(posedge clk_sys);
      rd(OFF_GROUP_STAT, rdv);
      chk("group status", rdv[3:0], {halt, req});
    end
    $display("status test done");
    wr(OFF_GROUP_STAT, 32'h0);
    for (i = 0; i < 10 && clr !== 1'b1; i++) @(posedge clk_sys);
    chk("clear pulse rises", clr, 1'b1);
    for (i = 0; i < 20 && clr !== 1'b0; i++) @(posedge clk_sys);
    chk("clear pulse ends", clr, 1'b0);
    $display("clear test done");
    wr(OFF_PORT_DIR, 32'hFFFF_FFFF);
    #5 reset = 1'b1;
    #1 chk("async reset oe", loe, 32'h0);
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFF_PORT_DIR, rdv);
    chk("dir after reset", rdv, RST_DIR);
    $display("reset mid-run test done");
    conclude;
  end
endmodule
bind hbud_top hbud_monitor u_hbud_monitor (.clk_sys(clk_sys), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_lines_out(port_lines_out), .port_lines_oe(port_lines_oe),
  .clear_pulse(clear_pulse), .group1_request_in(group1_request_in),
  .group1_acknowledge_out(group1_acknowledge_out),
  .group1_acknowledge_oe(group1_acknowledge_oe),
  .group1_peripheral_clock_oe(group1_peripheral_clock_oe),
  .group2_peripheral_clock_oe(group2_peripheral_clock_oe));
